// file: design/card_spi_pkg.sv
package card_spi_pkg;
  // ==========================================================
  // command indices
  localparam logic [5:0] CMD_RESET = 6'h00; // card reset
  localparam logic [5:0] CMD_WRITE_ONE = 6'h18; // single block write
  localparam logic [5:0] CMD_WRITE_MANY = 6'h19; // multiple block write
  localparam logic [5:0] CMD_PROG_CSD = 6'h1b; // program card data
  localparam logic [5:0] CMD_SET_PROT = 6'h1c; // set group protection
  localparam logic [5:0] CMD_CLR_PROT = 6'h1d; // clear group protection
  localparam logic [5:0] CMD_SEND_PROT = 6'h1e; // read protection bits
  localparam logic [5:0] CMD_SECT_FIRST = 6'h20; // first tagged sector
  localparam logic [5:0] CMD_SECT_LAST = 6'h21; // last tagged sector
  localparam logic [5:0] CMD_SECT_UNTAG = 6'h22; // untag one sector
  localparam logic [5:0] CMD_GRP_FIRST = 6'h23; // first tagged group
  localparam logic [5:0] CMD_GRP_LAST = 6'h24; // last tagged group
  localparam logic [5:0] CMD_GRP_UNTAG = 6'h25; // untag one group
  localparam logic [5:0] CMD_ERASE = 6'h26; // erase selection

  // ==========================================================
  // tokens and fixed bytes
  localparam logic [7:0] TOK_START_ONE = 8'hfe; // single block / payload start
  localparam logic [7:0] TOK_START_MANY = 8'hfc; // multi block start
  localparam logic [7:0] TOK_STOP = 8'hfd; // stop transmission
  localparam logic [7:0] IDLE_BYTE = 8'hff; // nothing to say, or ready
  localparam logic [7:0] BUSY_BYTE = 8'h00; // busy token
  localparam logic [7:0] DRESP_OK = 8'h05; // data accepted
  localparam logic [7:0] DRESP_WERR = 8'h0d; // data rejected, write error
  localparam logic [7:0] R1_CLEAR = 8'h00; // no flag raised

  // ==========================================================
  // r1 flag positions
  localparam int R1_IDLE = 0;
  localparam int R1_ILLEGAL = 2;
  localparam int R1_ERASE_SEQ = 4;
  localparam int R1_ADDR = 5;
  localparam int R1_PARAM = 6;

  // ==========================================================
  // sizes and counts
  localparam logic [2:0] CMD_LAST_BYTE = 3'h5; // crc byte of a frame
  localparam logic [11:0] CSD_BYTES = 12'h010; // card data block length
  localparam logic [12:0] PHYS_BLOCK_BYTES = 13'h0200; // physical block size
  localparam int SECTOR_SHIFT = 9; // byte address to sector
  localparam int WP_BITS = 32; // protection bits per payload
  localparam logic [15:0] CRC16_POLY = 16'h1021; // payload crc polynomial
  localparam logic [2:0] WP_LAST_BYTE = 3'h7; // last payload step
  localparam logic [47:0] WP_SHIFT_RESET = 48'h0;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic csd; // byte belongs to card data, not memory
    logic [31:0] addr; // byte address
    logic [7:0] data;
  } prog_t;

  typedef struct packed {
    logic group_mode; // ranges are erase groups, not sectors
    logic [31:0] first;
    logic [31:0] last;
    logic skip_valid; // one untagged entry present
    logic [31:0] skip;
  } erase_t;

  typedef enum {
    ST_IDLE, ST_CMD, ST_TOKEN, ST_DATA, ST_CRC, ST_WBUSY, ST_BUSY, ST_WP
  } state_t;
endpackage

// file: design/byte_fifo.sv
`timescale 1ns/10ps
module byte_fifo #(
  parameter int WIDTH = 41,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH]; // storage
  logic [AW-1:0] wr_ptr; // next slot to fill
  logic [AW-1:0] rd_ptr; // next slot to drain
  logic [AW:0] count; // words held in storage
  wire push = in_valid && in_ready;
  wire load = (count != '0) && (!out_valid || out_ready);
  wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(load);

  // full is honest: the output stage is not counted as a slot
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign empty = (count == '0) && !out_valid;

  // ==========================================================
  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // ==========================================================
  // pointers, count and registered read stage
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      count <= next_count;
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (load) begin
        out_data <= mem[rd_ptr];
        out_valid <= 1'b1;
        rd_ptr <= rd_ptr + AW'(1);
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule

// file: design/card_spi_cmd.sv
// Summary of operation
// - single block write, one block, busy answer
// - multi write until stop token or count
// - program card data block, busy answer
// - set protection bit of addressed group
// - clear protection bit of addressed group
// - answer then send protection bit payload
// - record first sector of erase selection
// - record last sector of sector range
// - untag one previously tagged sector
// - record first erase group of range
// - record last erase group of range
// - untag one previously tagged erase group
// - erase command erases whole tagged selection
// - busy bytes zero, nonzero once ready
// - no physical block crossing in a write's first block unless permitted
// - payload 32 bits, 16 crc, lsb first group
`timescale 1ns/10ps
module card_spi_cmd import card_spi_pkg::*; #(
  parameter int GROUPS = 64,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic [11:0] block_len,
  input wire logic [15:0] block_count,
  input wire logic [4:0] protect_group_size_field,
  input wire logic misaligned_write_permit,
  output prog_t prog,
  output logic prog_valid,
  input wire logic prog_ready,
  output erase_t erase_sel,
  output logic erase_start,
  input wire logic erase_done,
  output logic [GROUPS-1:0] protect_bits
);
  localparam int GW = $clog2(GROUPS);

  // ==========================================================
  // pin synchronisers, edges
  logic [2:0] pin_s1; // first stage
  logic [2:0] pin_s2; // {sclk, cs_b, mosi} in clk domain
  logic sclk_d; // previous sclk sample
  wire sclk_rise = pin_s2[2] && !sclk_d;
  wire sclk_fall = !pin_s2[2] && sclk_d;
  wire selected = !pin_s2[1];
  wire mosi_s = pin_s2[0];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_s1 <= 3'h3;
      pin_s2 <= 3'h3;
      sclk_d <= 1'b0;
    end else begin
      pin_s1 <= {sclk, cs_b, mosi};
      pin_s2 <= pin_s1;
      sclk_d <= pin_s2[2];
    end
  end

  // ==========================================================
  // byte engine: in on rise, out on fall
  logic [7:0] rx_shift; // bits gathered so far
  logic [2:0] bit_cnt; // bits of current byte seen
  logic [7:0] tx_shift; // byte being shifted out
  logic [7:0] tx_byte; // next slot's byte
  wire [7:0] rx_byte = {rx_shift[6:0], mosi_s};
  wire byte_evt = selected && sclk_rise && (bit_cnt == 3'h7);

  // receive side; deselect realigns the byte boundary
  always_ff @(posedge clk) begin
    if (!rst_b || !selected) begin
      bit_cnt <= 3'h0;
      rx_shift <= 8'h00;
    end else if (sclk_rise) begin
      rx_shift <= rx_byte;
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // transmit side; msb leaves on the fall ending the last byte
  always_ff @(posedge clk) begin
    if (!rst_b || !selected) begin
      tx_shift <= IDLE_BYTE;
      miso <= 1'b1;
      miso_oe <= 1'b0;
    end else begin
      miso_oe <= 1'b1;
      if (sclk_fall) begin
        if (bit_cnt == 3'h0) begin
          tx_shift <= tx_byte;
          miso <= tx_byte[7];
        end else begin
          tx_shift <= {tx_shift[6:0], 1'b0};
          miso <= tx_shift[6];
        end
      end
    end
  end

  // ==========================================================
  // sequencer registers
  state_t state;
  logic [2:0] fcnt; // frame byte count
  logic [11:0] cnt; // data byte count
  logic [5:0] cmd_idx;
  logic [31:0] arg;
  logic [31:0] addr; // address of current block
  logic multi; // multi block write in progress
  logic csd_mode; // data block targets card data
  logic limited; // block count preset
  logic [15:0] blocks_left;
  logic data_err; // byte dropped
  logic erase_busy; // erase running outside
  logic [47:0] wp_shift; // protection payload with crc
  logic first_ok; // range start recorded
  logic last_ok; // range end recorded
  logic sel_group; // selection holds groups
  logic [31:0] sel_first;
  logic [31:0] sel_last;
  logic sel_skip_valid;
  logic [31:0] sel_skip;

  // ==========================================================
  // fifo to programming port
  logic fifo_in_ready;
  logic fifo_empty;
  wire data_push = byte_evt && (state == ST_DATA);
  wire prog_t fifo_in = {csd_mode, addr + {20'h0, cnt}, rx_byte};

  byte_fifo #(
    .WIDTH($bits(prog_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_data(fifo_in),
    .in_valid(data_push),
    .in_ready(fifo_in_ready),
    .out_data(prog),
    .out_valid(prog_valid),
    .out_ready(prog_ready),
    .empty(fifo_empty)
  );

  // ==========================================================
  // argument decode
  wire [31:0] wp_group = (arg >> SECTOR_SHIFT) >> protect_group_size_field;
  wire group_ok = wp_group < 32'(GROUPS);
  wire [12:0] block_end = {4'h0, arg[8:0]} + {1'b0, block_len};
  wire misaligned = (block_end > PHYS_BLOCK_BYTES) && !misaligned_write_permit;
  wire [11:0] len_now = csd_mode ? CSD_BYTES : block_len;
  wire block_last = (cnt == len_now - 12'h1);
  wire more_blocks = multi && !(limited && blocks_left == 16'h0000);
  wire range_done = first_ok && last_ok;

  // lsb is first group, zero past the end
  logic [WP_BITS-1:0] wp_word;
  for (genvar i = 0; i < WP_BITS; i++) begin : g_wp
    wire [31:0] idx = wp_group + 32'(i);
    assign wp_word[i] = (idx < 32'(GROUPS)) && protect_bits[idx[GW-1:0]];
  end

  // payload crc, msb first
  function automatic logic [15:0] crc16(input logic [31:0] d);
    logic [15:0] c;
    c = 16'h0000;
    for (int k = 31; k >= 0; k--) begin
      c = c[15] ^ d[k] ? {c[14:0], 1'b0} ^ CRC16_POLY : {c[14:0], 1'b0};
    end
    return c;
  endfunction
  wire [15:0] wp_crc = crc16(wp_word);

  // ==========================================================
  // r1 flags and next state
  logic [7:0] r1;
  state_t follow;
  always_comb begin
    r1 = R1_CLEAR;
    follow = ST_IDLE;
    case (cmd_idx)
      CMD_RESET: begin
        r1[R1_IDLE] = 1'b1;
      end
      CMD_WRITE_ONE, CMD_WRITE_MANY: begin
        if (misaligned) begin
          r1[R1_ADDR] = 1'b1;
        end else begin
          follow = ST_TOKEN;
        end
      end
      CMD_PROG_CSD: begin
        follow = ST_TOKEN;
      end
      CMD_SET_PROT, CMD_CLR_PROT: begin
        r1[R1_PARAM] = !group_ok;
        follow = ST_BUSY;
      end
      CMD_SEND_PROT: begin
        follow = ST_WP;
      end
      CMD_SECT_FIRST, CMD_GRP_FIRST: begin
        r1 = R1_CLEAR;
      end
      CMD_SECT_LAST, CMD_SECT_UNTAG: begin
        r1[R1_ERASE_SEQ] = !first_ok || sel_group;
      end
      CMD_GRP_LAST, CMD_GRP_UNTAG: begin
        r1[R1_ERASE_SEQ] = !first_ok || !sel_group;
      end
      CMD_ERASE: begin
        r1[R1_ERASE_SEQ] = !range_done;
        follow = range_done ? ST_BUSY : ST_IDLE;
      end
      default: begin
        r1[R1_ILLEGAL] = 1'b1;
      end
    endcase
  end

  wire exec = byte_evt && (state == ST_CMD) && (fcnt == CMD_LAST_BYTE);
  wire seq_ok = (r1[R1_ERASE_SEQ] == 1'b0);

  // ==========================================================
  // main sequencer, one step per byte
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      fcnt <= 3'h0;
      cnt <= 12'h000;
      cmd_idx <= 6'h00;
      arg <= 32'h0;
      addr <= 32'h0;
      multi <= 1'b0;
      csd_mode <= 1'b0;
      limited <= 1'b0;
      blocks_left <= 16'h0;
      data_err <= 1'b0;
      wp_shift <= WP_SHIFT_RESET;
      tx_byte <= IDLE_BYTE;
    end else if (byte_evt) begin
      case (state)
        // wait for a 01 frame start
        ST_IDLE: begin
          tx_byte <= IDLE_BYTE;
          if (rx_byte[7:6] == 2'b01) begin
            cmd_idx <= rx_byte[5:0];
            fcnt <= 3'h1;
            state <= ST_CMD;
          end
        end
        // argument bytes, crc byte ends frame
        ST_CMD: begin
          fcnt <= fcnt + 3'h1;
          if (fcnt != CMD_LAST_BYTE) begin
            arg <= {arg[23:0], rx_byte};
          end else begin
            tx_byte <= r1; // r1 follows one byte after the frame
            state <= follow;
            cnt <= 12'h000;
            fcnt <= 3'h0;
            multi <= (cmd_idx == CMD_WRITE_MANY);
            csd_mode <= (cmd_idx == CMD_PROG_CSD);
            addr <= (cmd_idx == CMD_PROG_CSD) ? 32'h0 : arg;
            limited <= (block_count != 16'h0);
            blocks_left <= block_count;
            wp_shift <= {wp_word, wp_crc};
          end
        end
        // hunt for a token; stop ends a multi write
        ST_TOKEN: begin
          tx_byte <= IDLE_BYTE;
          data_err <= 1'b0;
          cnt <= 12'h000;
          if (rx_byte == (multi ? TOK_START_MANY : TOK_START_ONE)) begin
            state <= ST_DATA;
          end else if (multi && rx_byte == TOK_STOP) begin
            state <= ST_BUSY;
          end
        end
        // a full fifo cannot stall the host, so the block is marked bad
        ST_DATA: begin
          cnt <= cnt + 12'h001;
          if (!fifo_in_ready) begin
            data_err <= 1'b1;
          end
          if (block_last) begin
            cnt <= 12'h000;
            state <= ST_CRC;
          end
        end
        // two crc bytes, then the data response
        ST_CRC: begin
          cnt <= cnt + 12'h001;
          if (cnt != 12'h000) begin
            tx_byte <= data_err ? DRESP_WERR : DRESP_OK;
            addr <= addr + {20'h0, len_now};
            blocks_left <= blocks_left - 16'h1;
            state <= ST_WBUSY;
          end
        end
        // busy while block drains
        ST_WBUSY: begin
          if (fifo_empty) begin
            tx_byte <= IDLE_BYTE;
            state <= more_blocks ? ST_TOKEN : ST_IDLE;
          end else begin
            tx_byte <= BUSY_BYTE;
          end
        end
        // r1b busy for protection, stop and erase
        ST_BUSY: begin
          if (fifo_empty && !erase_busy) begin
            tx_byte <= IDLE_BYTE;
            state <= ST_IDLE;
          end else begin
            tx_byte <= BUSY_BYTE;
          end
        end
        // token, four protection bytes, crc
        ST_WP: begin
          fcnt <= fcnt + 3'h1;
          if (fcnt == 3'h0) begin
            tx_byte <= TOK_START_ONE;
          end else if (fcnt == WP_LAST_BYTE) begin
            tx_byte <= IDLE_BYTE;
            fcnt <= 3'h0;
            state <= ST_IDLE;
          end else begin
            tx_byte <= wp_shift[47:40];
            wp_shift <= {wp_shift[39:0], 8'h00};
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // group protection bits
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      protect_bits <= '0;
    end else if (exec && group_ok) begin
      if (cmd_idx == CMD_SET_PROT) begin
        protect_bits[wp_group[GW-1:0]] <= 1'b1;
      end else if (cmd_idx == CMD_CLR_PROT) begin
        protect_bits[wp_group[GW-1:0]] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // erase selection; a new start discards the old one
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      first_ok <= 1'b0;
      last_ok <= 1'b0;
      sel_group <= 1'b0;
      sel_first <= 32'h0;
      sel_last <= 32'h0;
      sel_skip_valid <= 1'b0;
      sel_skip <= 32'h0;
    end else if (exec && seq_ok) begin
      case (cmd_idx)
        CMD_SECT_FIRST, CMD_GRP_FIRST: begin
          sel_first <= arg;
          sel_group <= (cmd_idx == CMD_GRP_FIRST);
          first_ok <= 1'b1;
          last_ok <= 1'b0;
          sel_skip_valid <= 1'b0;
        end
        CMD_SECT_LAST, CMD_GRP_LAST: begin
          sel_last <= arg;
          last_ok <= 1'b1;
        end
        CMD_SECT_UNTAG, CMD_GRP_UNTAG: begin
          sel_skip <= arg;
          sel_skip_valid <= 1'b1;
        end
        CMD_RESET, CMD_ERASE: begin
          first_ok <= 1'b0; // consumed or dropped
          last_ok <= 1'b0;
          sel_skip_valid <= 1'b0;
        end
        default: begin
          first_ok <= first_ok;
        end
      endcase
    end
  end

  // ==========================================================
  // erase hand-off; start wins over a done in the same cycle
  wire erase_go = exec && (cmd_idx == CMD_ERASE) && range_done;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      erase_start <= 1'b0;
      erase_busy <= 1'b0;
      erase_sel <= '0;
    end else begin
      erase_start <= erase_go;
      if (erase_go) begin
        erase_busy <= 1'b1;
        erase_sel <= {sel_group, sel_first, sel_last,
                      sel_skip_valid, sel_skip};
      end else if (erase_done) begin
        erase_busy <= 1'b0;
      end
    end
  end
endmodule

// file: bench/card_spi_cmd_props.sv
`timescale 1ns/10ps
// ==========================================================
// port checker
module card_spi_cmd_props import card_spi_pkg::*; #(
  parameter int GROUPS = 64
) (
  input logic clk,
  input logic rst_b,
  input logic cs_b,
  input logic miso,
  input logic miso_oe,
  input prog_t prog,
  input logic prog_valid,
  input logic prog_ready,
  input erase_t erase_sel,
  input logic erase_start,
  input logic [GROUPS-1:0] protect_bits
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // programming port
  sequence s_stall;
    prog_valid && !prog_ready;
  endsequence
  sequence s_take;
    prog_valid && prog_ready && !prog.csd;
  endsequence
  property p_prog_hold;
    s_stall |=> prog_valid && $stable(prog);
  endproperty
  a_prog_hold: assert property (p_prog_hold) else $error("byte changed while stalled");
  // memory bytes step by one
  property p_prog_seq;
    s_take ##1 (prog_valid && !prog.csd) |-> prog.addr == $past(prog.addr) + 32'h1;
  endproperty
  a_prog_seq: assert property (p_prog_seq) else $error("write address skipped");
  property p_csd;
    prog_valid && prog.csd |-> prog.addr < 32'h10;
  endproperty
  a_csd: assert property (p_csd) else $error("card data byte out of range");
  // ==========================================================
  // erase and protection
  property p_erase_pulse;
    $rose(erase_start) |=> !erase_start;
  endproperty
  a_erase_pulse: assert property (p_erase_pulse) else $error("erase start too long");
  property p_sel_load;
    $changed(erase_sel) |-> erase_start;
  endproperty
  a_sel_load: assert property (p_sel_load) else $error("selection moved without erase");
  // erase only from an answered frame
  property p_erase_framed;
    erase_start |-> !cs_b && miso_oe;
  endproperty
  a_erase_framed: assert property (p_erase_framed) else $error("erase outside a frame");
  property p_protect_one;
    $changed(protect_bits) |-> $onehot(protect_bits ^ $past(protect_bits));
  endproperty
  a_protect_one: assert property (p_protect_one) else $error("several groups changed");
  // reset silences outputs
  property p_reset;
    disable iff (1'b0) !rst_b |=> !miso_oe && miso && !prog_valid && !erase_start && erase_sel == '0
      && protect_bits == '0;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not quiet in reset");
endmodule
bind card_spi_cmd card_spi_cmd_props #(.GROUPS(GROUPS)) props (.*);

// file: bench/spi_host_model.sv
`timescale 1ns/10ps
// ==========================================================
// link host: mode 0, msb first, clock idle between bytes
module spi_host_model (
  input wire logic clk,
  input wire logic miso,
  output logic sclk,
  output logic cs_b,
  output logic mosi
);
  int gap; // idle cycles before a byte
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    mosi = 1'b1;
    gap = 0;
  end
  // one byte each way, 200 ns per bit
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    repeat (gap) @(posedge clk);
    for (int i = 7; i >= 0; i--) begin
      mosi <= tx[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      rx[i] = miso;
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
    end
  endtask
  task automatic sel(input logic v);
    repeat (8) @(posedge clk);
    cs_b <= v;
    repeat (8) @(posedge clk);
  endtask
  // six byte frame, then the answer slot
  task automatic cmd(input logic [5:0] idx, input logic [31:0] arg, output logic [7:0] r1);
    logic [7:0] d;
    xfer({2'b01, idx}, d);
    for (int i = 3; i >= 0; i--) xfer(arg[8*i +: 8], d);
    xfer(8'h95, d);
    xfer(8'hff, r1);
  endtask
endmodule

// file: bench/tb_card_spi_cmd.sv
`timescale 1ns/10ps
// ==========================================================
// decoder bench
module tb_card_spi_cmd import card_spi_pkg::*;;
  logic clk, rst_b, prog_ready, erase_done, misaligned_write_permit, stall;
  logic [11:0] block_len;
  logic [15:0] block_count;
  logic [4:0] protect_group_size_field;
  logic [63:0] protect_bits;
  logic miso, miso_oe, prog_valid, erase_start, sclk, cs_b, mosi;
  prog_t prog;
  erase_t erase_sel;
  prog_t got[$]; // bytes taken off the programming port
  int mismatches, comparisons, cycles, ecnt, nerase;
  wire miso_line = miso_oe ? miso : 1'b1; // pulled up when released

  card_spi_cmd #(.GROUPS(64), .FIFO_DEPTH(16)) uut (.*);
  spi_host_model host (.clk(clk), .miso(miso_line), .sclk(sclk), .cs_b(cs_b), .mosi(mosi));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ==========================================================
  // consumer takes every other cycle while not stalled; erase takes 200 cycles; watchdog
  always @(posedge clk) begin
    cycles <= cycles + 1;
    prog_ready <= !stall && !prog_ready;
    if (prog_valid && prog_ready) got.push_back(prog);
    if (erase_start) nerase <= nerase + 1;
    ecnt <= erase_start ? 200 : (ecnt > 0 ? ecnt - 1 : 0);
    erase_done <= (ecnt == 1);
    if (cycles == 60000) begin
      mismatches++;
      wrap_up;
    end
  end
  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] seen);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cmd_chk(input string what, input logic [5:0] idx, input logic [31:0] arg, input logic [7:0] exp);
    logic [7:0] r;
    host.cmd(idx, arg, r);
    chk(what, exp, r);
  endtask
  task automatic ff_chk(input string what);
    logic [7:0] d;
    host.xfer(8'hff, d);
    chk(what, IDLE_BYTE, d);
  endtask
  // token, n bytes a0.., two crc bytes, then the data response
  task automatic blk(input logic [7:0] tok, input int n, output logic [7:0] resp);
    logic [7:0] d;
    host.xfer(tok, d);
    for (int i = 0; i < n; i++) host.xfer(8'ha0 + 8'(i), d);
    repeat (2) host.xfer(8'hff, d);
    host.xfer(8'hff, resp);
  endtask
  // busy bytes until ready; consumer freed after the first
  task automatic wait_ready(input string what, input logic must_busy);
    logic [7:0] d;
    int n;
    host.xfer(8'hff, d);
    if (must_busy) chk({what, " busy"}, BUSY_BYTE, d);
    stall <= 1'b0;
    n = 0;
    while (d !== IDLE_BYTE && n < 300) begin
      host.xfer(8'hff, d);
      n++;
    end
    chk({what, " ready"}, IDLE_BYTE, d);
  endtask
  task automatic chk_got(input logic [31:0] base, input logic csd, input int n, input int len);
    chk("prog count", n, got.size());
    foreach (got[i]) chk("prog word", {csd, base + 32'(i), 8'ha0 + 8'(i % len)}, got[i]);
    got.delete();
  endtask
  task automatic wp_read(input logic [31:0] arg, input logic [31:0] exp);
    logic [31:0] w;
    logic [7:0] d;
    cmd_chk("wp r1", CMD_SEND_PROT, arg, R1_CLEAR);
    host.xfer(8'hff, d);
    chk("wp token", TOK_START_ONE, d);
    for (int i = 3; i >= 0; i--) host.xfer(8'hff, w[8*i +: 8]);
    chk("wp bits", exp, w);
    repeat (2) host.xfer(8'hff, d);
    ff_chk("wp end");
  endtask
  // ==========================================================
  // scenarios
  task automatic t_illegal;
    logic [5:0] idx[4] = '{6'h1a, 6'h1f, 6'h01, 6'h27};
    foreach (idx[i]) cmd_chk("illegal r1", idx[i], 32'h0, 8'h04);
  endtask
  // field 1: two sectors per group
  task automatic t_protect;
    cmd_chk("set r1", CMD_SET_PROT, 32'h0000_0a00, R1_CLEAR);
    ff_chk("set tail");
    cmd_chk("set r1", CMD_SET_PROT, 32'h0000_fc00, R1_CLEAR);
    ff_chk("set tail");
    cmd_chk("range r1", CMD_SET_PROT, 32'h0001_0000, 8'h40);
    ff_chk("range tail");
    chk("protect", 64'h8000_0000_0000_0004, protect_bits);
    wp_read(32'h0, 32'h0000_0004);
    wp_read(32'h0000_a000, 32'h0080_0000);
    cmd_chk("clr r1", CMD_CLR_PROT, 32'h0000_0a00, R1_CLEAR);
    ff_chk("clr tail");
    chk("protect", 64'h8000_0000_0000_0000, protect_bits);
  endtask
  task automatic t_write;
    logic [7:0] d;
    cmd_chk("misalign r1", CMD_WRITE_ONE, 32'h0000_01fe, 8'h20);
    stall <= 1'b1;
    cmd_chk("write r1", CMD_WRITE_ONE, 32'h0000_0400, R1_CLEAR);
    blk(TOK_START_ONE, 4, d);
    chk("write resp", DRESP_OK, d);
    wait_ready("write", 1'b1);
    chk_got(32'h0000_0400, 1'b0, 4, 4);
    block_len <= 12'h014;
    stall <= 1'b1;
    cmd_chk("full r1", CMD_WRITE_ONE, 32'h0000_0c00, R1_CLEAR);
    blk(TOK_START_ONE, 20, d);
    chk("full resp", DRESP_WERR, d);
    wait_ready("full", 1'b1);
    got.delete();
    block_len <= 12'h004;
  endtask
  // open ended multi write from a slow host, ended by the stop token, then a one block counted multi write
  task automatic t_multi;
    logic [7:0] d;
    host.gap = 40;
    stall <= 1'b1;
    cmd_chk("multi r1", CMD_WRITE_MANY, 32'h0000_0800, R1_CLEAR);
    repeat (2) begin
      blk(TOK_START_MANY, 4, d);
      chk("multi resp", DRESP_OK, d);
      wait_ready("multi", 1'b1);
      stall <= 1'b1;
    end
    host.xfer(TOK_STOP, d);
    wait_ready("stop", 1'b0);
    chk_got(32'h0000_0800, 1'b0, 8, 4);
    block_count <= 16'h0001;
    cmd_chk("count r1", CMD_WRITE_MANY, 32'h0000_0800, R1_CLEAR);
    blk(TOK_START_MANY, 4, d);
    wait_ready("count", 1'b0);
    chk_got(32'h0000_0800, 1'b0, 4, 4);
    block_count <= 16'h0000;
    host.gap = 0;
  endtask
  task automatic t_csd;
    logic [7:0] d;
    stall <= 1'b1;
    cmd_chk("csd r1", CMD_PROG_CSD, 32'h0, R1_CLEAR);
    blk(TOK_START_ONE, 16, d);
    chk("csd resp", DRESP_OK, d);
    wait_ready("csd", 1'b1);
    chk_got(32'h0, 1'b1, 16, 16);
  endtask
  // sector, then group selection
  task automatic t_erase;
    cmd_chk("reset r1", CMD_RESET, 32'h0, 8'h01);
    cmd_chk("order r1", CMD_SECT_LAST, 32'h0000_1000, 8'h10);
    for (int m = 0; m < 2; m++) begin
      cmd_chk("first r1", m ? CMD_GRP_FIRST : CMD_SECT_FIRST, 32'h0000_0200, R1_CLEAR);
      cmd_chk("last r1", m ? CMD_GRP_LAST : CMD_SECT_LAST, 32'h0000_1000, R1_CLEAR);
      cmd_chk("untag r1", m ? CMD_GRP_UNTAG : CMD_SECT_UNTAG, 32'h0000_0600, R1_CLEAR);
      cmd_chk("erase r1", CMD_ERASE, 32'h0, R1_CLEAR);
      wait_ready("erase", 1'b1);
      chk("erase sel", {m[0], 32'h0000_0200, 32'h0000_1000, 1'b1, 32'h0000_0600}, erase_sel);
    end
    chk("erase count", 2, nerase);
  endtask
  initial begin
    {rst_b, prog_ready, erase_done, misaligned_write_permit, stall} = 5'h00;
    block_len = 12'h004;
    block_count = 16'h0000;
    protect_group_size_field = 5'h01;
    {mismatches, comparisons, cycles, ecnt, nerase} = '0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    host.sel(1'b0);
    t_illegal;
    t_protect;
    host.sel(1'b1);
    host.sel(1'b0);
    t_write;
    t_multi;
    t_csd;
    t_erase;
    wrap_up;
  end
endmodule
